// *** logic/ocd_pkg.sv ***
// Purpose: Shared constants and types for the one-byte opcode decoder.
// Assumes: One clock state of execution equals one ref_clk cycle.
// Notes: Opcode patterns use ? for bits that carry an operand field.
package ocd_pkg;

  // Field positions inside an opcode byte.
  localparam int OCD_DST_HI = 5;
  localparam int OCD_DST_LO = 3;
  localparam int OCD_SRC_HI = 2;
  localparam int OCD_SRC_LO = 0;
  localparam int OCD_PAIR_HI = 5;
  localparam int OCD_PAIR_LO = 4;
  localparam int OCD_COND_HI = 5;
  localparam int OCD_COND_LO = 3;

  // Counter and output widths.
  localparam int OCD_CNT_W = 5;

  // Exact opcodes.
  localparam logic [7:0] OCD_OPC_CALL = 8'hCD;
  localparam logic [7:0] OCD_OPC_RET = 8'hC9;
  localparam logic [7:0] OCD_OPC_ADC_IMM = 8'hCE;
  localparam logic [7:0] OCD_OPC_ADC_MEM = 8'h8E;
  localparam logic [7:0] OCD_OPC_IMM_MEM = 8'h36;
  localparam logic [7:0] OCD_OPC_AND_IMM = 8'hE6;
  localparam logic [7:0] OCD_OPC_ACC_INV = 8'h2F;
  localparam logic [7:0] OCD_OPC_CARRY_SET = 8'h37;
  localparam logic [7:0] OCD_OPC_CARRY_INV = 8'h3F;
  localparam logic [7:0] OCD_OPC_DEC_ADJ = 8'h27;
  localparam logic [7:0] OCD_OPC_INT_ALLOW = 8'hFB;
  localparam logic [7:0] OCD_OPC_INT_BLOCK = 8'hF3;
  localparam logic [7:0] OCD_OPC_IDLE = 8'h00;
  localparam logic [7:0] OCD_OPC_PAIR_STORE = 8'h22;
  localparam logic [7:0] OCD_OPC_PAIR_LOAD = 8'h2A;

  // Opcode patterns with operand fields left open.
  localparam logic [7:0] OCD_PAT_CALL_COND = 8'b11???100;
  localparam logic [7:0] OCD_PAT_RET_COND = 8'b11???000;
  localparam logic [7:0] OCD_PAT_PAIR_DEC = 8'b00??1011;
  localparam logic [7:0] OCD_PAT_ADC_REG = 8'b10001???;
  localparam logic [7:0] OCD_PAT_IMM_REG = 8'b00???110;
  localparam logic [7:0] OCD_PAT_STORE_MEM = 8'b01110???;
  localparam logic [7:0] OCD_PAT_LOAD_MEM = 8'b01???110;
  localparam logic [7:0] OCD_PAT_REG_COPY = 8'b01??????;

  // Execution lengths in clock states.
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_CALL = 5'h11;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_CALL_SKIP = 5'h0B;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_RET = 5'h0A;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_RET_TAKEN = 5'h0B;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_RET_SKIP = 5'h05;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_PAIR_DEC = 5'h05;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_IMM = 5'h07;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_ADC_REG = 5'h04;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_IMM_MEM = 5'h0A;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_MEM = 5'h07;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_REG_COPY = 5'h05;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_SINGLE = 5'h04;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_DIRECT = 5'h10;
  localparam logic [OCD_CNT_W-1:0] OCD_LEN_UNKNOWN = 5'h01;

  // Values after reset.
  localparam logic [OCD_CNT_W-1:0] OCD_RST_CNT = 5'h00;
  localparam logic [2:0] OCD_RST_FIELD = 3'h0;
  localparam logic [1:0] OCD_RST_PAIR = 2'h0;
  localparam logic [7:0] OCD_RST_SEL = 8'h00;

  // Register field codes.
  typedef enum logic [2:0] {
    OCD_REG_B = 3'h0,
    OCD_REG_C = 3'h1,
    OCD_REG_D = 3'h2,
    OCD_REG_E = 3'h3,
    OCD_REG_H = 3'h4,
    OCD_REG_L = 3'h5,
    OCD_REG_MEM = 3'h6,
    OCD_REG_A = 3'h7
  } ocd_reg_t;

  // Condition field codes.
  typedef enum logic [2:0] {
    OCD_CC_NZ = 3'h0,
    OCD_CC_Z = 3'h1,
    OCD_CC_NC = 3'h2,
    OCD_CC_C = 3'h3,
    OCD_CC_PO = 3'h4,
    OCD_CC_PE = 3'h5,
    OCD_CC_P = 3'h6,
    OCD_CC_M = 3'h7
  } ocd_cond_t;

  // Decoded instruction class.
  typedef enum logic [4:0] {
    OCD_OP_UNKNOWN = 5'h00,
    OCD_OP_CALL = 5'h01,
    OCD_OP_CALL_COND = 5'h02,
    OCD_OP_RET = 5'h03,
    OCD_OP_RET_COND = 5'h04,
    OCD_OP_PAIR_DEC = 5'h05,
    OCD_OP_ADC_IMM = 5'h06,
    OCD_OP_ADC_MEM = 5'h07,
    OCD_OP_ADC_REG = 5'h08,
    OCD_OP_IMM_MEM = 5'h09,
    OCD_OP_IMM_REG = 5'h0A,
    OCD_OP_STORE_MEM = 5'h0B,
    OCD_OP_LOAD_MEM = 5'h0C,
    OCD_OP_REG_COPY = 5'h0D,
    OCD_OP_AND_IMM = 5'h0E,
    OCD_OP_ACC_INV = 5'h0F,
    OCD_OP_CARRY_SET = 5'h10,
    OCD_OP_CARRY_INV = 5'h11,
    OCD_OP_DEC_ADJ = 5'h12,
    OCD_OP_INT_ALLOW = 5'h13,
    OCD_OP_INT_BLOCK = 5'h14,
    OCD_OP_IDLE = 5'h15,
    OCD_OP_PAIR_STORE = 5'h16,
    OCD_OP_PAIR_LOAD = 5'h17
  } ocd_op_t;

  // Decoder sequencing states.
  typedef enum logic [1:0] {
    OCD_ST_IDLE = 2'b01,
    OCD_ST_RUN = 2'b10
  } ocd_state_t;

endpackage

// *** logic/ocd_reg_field.sv ***
// Purpose: Turns a three-bit register field into a one-hot register select.
// Assumes: Pure combinational, used for both destination and source fields.
// Notes: Bit six of the select stands for the memory operand at H and L.
`timescale 1ns/1ps
module ocd_reg_field
  import ocd_pkg::*;
(
  // Field in.
  input wire logic [2:0] field,
  // Select out.
  output logic [7:0] sel,
  output logic is_mem
);

  always_comb begin
    sel = 8'h00;
    case (ocd_reg_t'(field))
      OCD_REG_B: sel = 8'h01;
      OCD_REG_C: sel = 8'h02;
      OCD_REG_D: sel = 8'h04;
      OCD_REG_E: sel = 8'h08;
      OCD_REG_H: sel = 8'h10;
      OCD_REG_L: sel = 8'h20;
      OCD_REG_MEM: sel = 8'h40;
      OCD_REG_A: sel = 8'h80;
      default: sel = 8'h00;
    endcase
  end

  assign is_mem = (field == OCD_REG_MEM);

endmodule

// *** logic/ocd_cond_eval.sv ***
// Purpose: Decides whether a condition field is met by the current flags.
// Assumes: Flags come from logic on the same clock.
// Notes: Pure combinational.
`timescale 1ns/1ps
module ocd_cond_eval
  import ocd_pkg::*;
(
  // Condition and flags.
  input wire logic [2:0] cond,
  input wire logic flag_zero,
  input wire logic flag_carry,
  input wire logic flag_parity,
  input wire logic flag_sign,
  // Result.
  output logic taken
);

  always_comb begin
    taken = 1'b0;
    case (ocd_cond_t'(cond))
      OCD_CC_NZ: taken = !flag_zero;
      OCD_CC_Z: taken = flag_zero;
      OCD_CC_NC: taken = !flag_carry;
      OCD_CC_C: taken = flag_carry;
      OCD_CC_PO: taken = !flag_parity;
      OCD_CC_PE: taken = flag_parity;
      OCD_CC_P: taken = !flag_sign;
      OCD_CC_M: taken = flag_sign;
      default: taken = 1'b0;
    endcase
  end

endmodule

// *** logic/ocd_decoder.sv ***
// Purpose: Decodes one-byte opcodes, gives operand fields and counts execution states.
// Assumes: Opcode, strobe and flags come from fetch logic on ref_clk; one state per cycle.
// Notes: An opcode is taken only while ready is high; done pulses when its states have run.
`timescale 1ns/1ps
module ocd_decoder
  import ocd_pkg::*;
(
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Opcode from fetch.
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  // Flags from the processor.
  input wire logic flag_zero,
  input wire logic flag_carry,
  input wire logic flag_parity,
  input wire logic flag_sign,
  // Handshake.
  output logic ready,
  output logic done,
  // Decoded result.
  output ocd_op_t op_class,
  output logic op_unknown,
  output logic [2:0] destination_field,
  output logic [2:0] source_field,
  output logic [7:0] dst_sel,
  output logic [7:0] src_sel,
  output logic [1:0] pair_field,
  output logic [2:0] cond_field,
  output logic cond_taken,
  output logic [1:0] imm_bytes,
  output logic writes_flags,
  output logic mem_access,
  output logic [OCD_CNT_W-1:0] op_states
);

  function automatic ocd_op_t classify(input logic [7:0] op);
    logic dmem;
    logic smem;
    dmem = (op[OCD_DST_HI:OCD_DST_LO] == OCD_REG_MEM);
    smem = (op[OCD_SRC_HI:OCD_SRC_LO] == OCD_REG_MEM);
    classify = OCD_OP_UNKNOWN;
    casez (op)
      OCD_OPC_CALL: classify = OCD_OP_CALL;
      OCD_OPC_RET: classify = OCD_OP_RET;
      OCD_OPC_ADC_IMM: classify = OCD_OP_ADC_IMM;
      OCD_OPC_ADC_MEM: classify = OCD_OP_ADC_MEM;
      OCD_OPC_IMM_MEM: classify = OCD_OP_IMM_MEM;
      OCD_OPC_AND_IMM: classify = OCD_OP_AND_IMM;
      OCD_OPC_ACC_INV: classify = OCD_OP_ACC_INV;
      OCD_OPC_CARRY_SET: classify = OCD_OP_CARRY_SET;
      OCD_OPC_CARRY_INV: classify = OCD_OP_CARRY_INV;
      OCD_OPC_DEC_ADJ: classify = OCD_OP_DEC_ADJ;
      OCD_OPC_INT_ALLOW: classify = OCD_OP_INT_ALLOW;
      OCD_OPC_INT_BLOCK: classify = OCD_OP_INT_BLOCK;
      OCD_OPC_IDLE: classify = OCD_OP_IDLE;
      OCD_OPC_PAIR_STORE: classify = OCD_OP_PAIR_STORE;
      OCD_OPC_PAIR_LOAD: classify = OCD_OP_PAIR_LOAD;
      OCD_PAT_CALL_COND: classify = OCD_OP_CALL_COND;
      OCD_PAT_RET_COND: classify = OCD_OP_RET_COND;
      OCD_PAT_PAIR_DEC: classify = OCD_OP_PAIR_DEC;
      OCD_PAT_ADC_REG: classify = smem ? OCD_OP_UNKNOWN : OCD_OP_ADC_REG;
      OCD_PAT_IMM_REG: classify = dmem ? OCD_OP_UNKNOWN : OCD_OP_IMM_REG;
      OCD_PAT_STORE_MEM: classify = smem ? OCD_OP_UNKNOWN : OCD_OP_STORE_MEM;
      OCD_PAT_LOAD_MEM: classify = dmem ? OCD_OP_UNKNOWN : OCD_OP_LOAD_MEM;
      OCD_PAT_REG_COPY: classify = (dmem || smem) ? OCD_OP_UNKNOWN : OCD_OP_REG_COPY;
      default: classify = OCD_OP_UNKNOWN;
    endcase
  endfunction

  function automatic logic [OCD_CNT_W-1:0] length_of(input ocd_op_t cls, input logic taken);
    length_of = OCD_LEN_UNKNOWN;
    case (cls)
      OCD_OP_CALL: length_of = OCD_LEN_CALL;
      OCD_OP_RET: length_of = OCD_LEN_RET;
      OCD_OP_CALL_COND: length_of = taken ? OCD_LEN_CALL : OCD_LEN_CALL_SKIP;
      OCD_OP_RET_COND: length_of = taken ? OCD_LEN_RET_TAKEN : OCD_LEN_RET_SKIP;
      OCD_OP_PAIR_DEC: length_of = OCD_LEN_PAIR_DEC;
      OCD_OP_ADC_IMM, OCD_OP_AND_IMM, OCD_OP_IMM_REG: length_of = OCD_LEN_IMM;
      OCD_OP_ADC_MEM, OCD_OP_STORE_MEM, OCD_OP_LOAD_MEM: length_of = OCD_LEN_MEM;
      OCD_OP_ADC_REG: length_of = OCD_LEN_ADC_REG;
      OCD_OP_IMM_MEM: length_of = OCD_LEN_IMM_MEM;
      OCD_OP_REG_COPY: length_of = OCD_LEN_REG_COPY;
      OCD_OP_PAIR_STORE, OCD_OP_PAIR_LOAD: length_of = OCD_LEN_DIRECT;
      OCD_OP_ACC_INV, OCD_OP_CARRY_SET, OCD_OP_CARRY_INV, OCD_OP_DEC_ADJ, OCD_OP_INT_ALLOW, OCD_OP_INT_BLOCK,
        OCD_OP_IDLE: length_of = OCD_LEN_SINGLE;
      default: length_of = OCD_LEN_UNKNOWN;
    endcase
  endfunction

  ocd_state_t state;
  ocd_state_t next_state;
  logic [OCD_CNT_W-1:0] cnt;
  logic take;
  logic last;
  logic taken_now;
  ocd_op_t cls_now;
  logic [7:0] dst_sel_now;
  logic [7:0] src_sel_now;
  logic dst_mem_now;
  logic src_mem_now;

  ocd_reg_field u_dst (
    .field(opcode[OCD_DST_HI:OCD_DST_LO]),
    .sel(dst_sel_now),
    .is_mem(dst_mem_now)
  );

  ocd_reg_field u_src (
    .field(opcode[OCD_SRC_HI:OCD_SRC_LO]),
    .sel(src_sel_now),
    .is_mem(src_mem_now)
  );

  ocd_cond_eval u_cond (
    .cond(opcode[OCD_COND_HI:OCD_COND_LO]),
    .flag_zero(flag_zero),
    .flag_carry(flag_carry),
    .flag_parity(flag_parity),
    .flag_sign(flag_sign),
    .taken(taken_now)
  );

  assign cls_now = classify(opcode);
  assign take = ce && (state == OCD_ST_IDLE) && opcode_valid;
  assign last = (state == OCD_ST_RUN) && (cnt == 5'h01);

  // Sequencing between waiting for an opcode and running its states.
  always_comb begin
    next_state = state;
    case (state)
      OCD_ST_IDLE: next_state = opcode_valid ? OCD_ST_RUN : OCD_ST_IDLE;
      OCD_ST_RUN: next_state = (cnt == 5'h01) ? OCD_ST_IDLE : OCD_ST_RUN;
      default: next_state = OCD_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= OCD_ST_IDLE;
      ready <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      ready <= (next_state == OCD_ST_IDLE);
    end
  end

  // State counter and completion pulse.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= OCD_RST_CNT;
      done <= 1'b0;
    end else if (ce) begin
      done <= last;
      if (take) begin
        cnt <= length_of(cls_now, taken_now);
      end else if (state == OCD_ST_RUN) begin
        cnt <= cnt - 5'h01;
      end
    end
  end

  // Decoded fields held for the whole instruction.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      op_class <= OCD_OP_UNKNOWN;
      op_unknown <= 1'b0;
      destination_field <= OCD_RST_FIELD;
      source_field <= OCD_RST_FIELD;
      dst_sel <= OCD_RST_SEL;
      src_sel <= OCD_RST_SEL;
      pair_field <= OCD_RST_PAIR;
      cond_field <= OCD_RST_FIELD;
      cond_taken <= 1'b0;
      op_states <= OCD_RST_CNT;
    end else if (take) begin
      op_class <= cls_now;
      op_unknown <= (cls_now == OCD_OP_UNKNOWN);
      destination_field <= opcode[OCD_DST_HI:OCD_DST_LO];
      source_field <= opcode[OCD_SRC_HI:OCD_SRC_LO];
      dst_sel <= dst_sel_now;
      src_sel <= src_sel_now;
      pair_field <= opcode[OCD_PAIR_HI:OCD_PAIR_LO];
      cond_field <= opcode[OCD_COND_HI:OCD_COND_LO];
      cond_taken <= taken_now;
      op_states <= length_of(cls_now, taken_now);
    end
  end

  // Operand bytes, flag effect and memory use of the taken opcode.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      imm_bytes <= 2'h0;
      writes_flags <= 1'b0;
      mem_access <= 1'b0;
    end else if (take) begin
      imm_bytes <= 2'h0;
      writes_flags <= 1'b0;
      mem_access <= 1'b0;
      case (cls_now)
        OCD_OP_CALL, OCD_OP_CALL_COND, OCD_OP_PAIR_STORE, OCD_OP_PAIR_LOAD: begin
          imm_bytes <= 2'h2;
          mem_access <= 1'b1;
        end
        OCD_OP_RET, OCD_OP_RET_COND, OCD_OP_STORE_MEM, OCD_OP_LOAD_MEM: begin
          mem_access <= 1'b1;
        end
        OCD_OP_ADC_IMM, OCD_OP_AND_IMM: begin
          imm_bytes <= 2'h1;
          writes_flags <= 1'b1;
        end
        OCD_OP_ADC_MEM: begin
          writes_flags <= 1'b1;
          mem_access <= 1'b1;
        end
        OCD_OP_ADC_REG, OCD_OP_DEC_ADJ, OCD_OP_CARRY_SET, OCD_OP_CARRY_INV: begin
          writes_flags <= 1'b1;
        end
        OCD_OP_IMM_MEM: begin
          imm_bytes <= 2'h1;
          mem_access <= 1'b1;
        end
        OCD_OP_IMM_REG: begin
          imm_bytes <= 2'h1;
        end
        default: begin
          imm_bytes <= 2'h0;
        end
      endcase
    end
  end

  sequence take_s(logic [7:0] code);
    take && (opcode == code);
  endsequence

  property length_p(logic [7:0] code, logic [OCD_CNT_W-1:0] len);
    @(posedge ref_clk) disable iff (!nrst)
      take_s(code) |=> (op_states == len) && !ready;
  endproperty

  call_length_a: assert property (length_p(OCD_OPC_CALL, 5'h11))
    else $error("invoke length wrong");
  ret_length_a: assert property (length_p(OCD_OPC_RET, 5'h0A))
    else $error("return length wrong");
  adc_imm_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_s(OCD_OPC_ADC_IMM) |=> op_class == OCD_OP_ADC_IMM && op_states == 5'h07 && imm_bytes == 2'h1 && writes_flags)
    else $error("immediate add with carry wrong");
  adc_mem_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_s(OCD_OPC_ADC_MEM) |=> op_class == OCD_OP_ADC_MEM && op_states == 5'h07 && mem_access)
    else $error("memory add with carry wrong");
  imm_mem_a: assert property (length_p(OCD_OPC_IMM_MEM, 5'h0A))
    else $error("immediate to memory length wrong");
  and_imm_a: assert property (length_p(OCD_OPC_AND_IMM, 5'h07))
    else $error("immediate and length wrong");
  single_byte_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && (opcode inside {8'h2F, 8'h37, 8'h3F, 8'h27, 8'hFB, 8'hF3, 8'h00}) |=> op_states == 5'h04)
    else $error("single byte length wrong");
  direct_pair_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && (opcode inside {8'h22, 8'h2A}) |=> op_states == 5'h10 && imm_bytes == 2'h2)
    else $error("direct pair transfer wrong");
  cond_call_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[7:6] == 2'h3 && opcode[2:0] == 3'h4 |=>
      op_states == ($past(taken_now) ? 5'h11 : 5'h0B) && cond_taken == $past(taken_now))
    else $error("conditional invoke length wrong");
  cond_ret_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[7:6] == 2'h3 && opcode[2:0] == 3'h0 |=> op_states == ($past(taken_now) ? 5'h0B : 5'h05))
    else $error("conditional return length wrong");
  pair_dec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[7:6] == 2'h0 && opcode[3:0] == 4'hB |=>
      op_class == OCD_OP_PAIR_DEC && pair_field == $past(opcode[5:4]) && op_states == 5'h05 && !writes_flags)
    else $error("pair decrement wrong");
  adc_reg_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[7:3] == 5'h11 && opcode[2:0] != 3'h6 |=> op_class == OCD_OP_ADC_REG && op_states == 5'h04)
    else $error("register add with carry wrong");
  imm_reg_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[7:6] == 2'h0 && opcode[2:0] == 3'h6 && opcode[5:3] != 3'h6 |=>
      op_states == 5'h07 && imm_bytes == 2'h1)
    else $error("immediate to register wrong");
  store_mem_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[7:3] == 5'h0E && opcode[2:0] != 3'h6 |=> op_class == OCD_OP_STORE_MEM && op_states == 5'h07)
    else $error("register to memory wrong");
  load_mem_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[7:6] == 2'h1 && opcode[2:0] == 3'h6 && opcode[5:3] != 3'h6 |=>
      op_class == OCD_OP_LOAD_MEM && op_states == 5'h07 && dst_sel == (8'h01 << $past(opcode[5:3])))
    else $error("memory to register wrong");
  reg_copy_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[7:6] == 2'h1 && opcode[2:0] != 3'h6 && opcode[5:3] != 3'h6 |=> op_states == 5'h05)
    else $error("register copy wrong");
  field_mem_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && opcode[5:3] == 3'h6 |=> dst_sel == 8'h40)
    else $error("memory field select wrong");
  busy_end_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ce && last |=> (done && ready) ##1 (!done || !$past(ce)))
    else $error("completion timing wrong");

endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the one-byte opcode decoder.
// Assumes: Inputs change on the falling edge of ref_clk; one state is one cycle.
// Notes: Each run issues an opcode at the falling edge where the previous one completed.
`timescale 1ns/1ps
module tb;
  import ocd_pkg::*;
  logic ref_clk, nrst, ce, opcode_valid, flag_zero, flag_carry, flag_parity, flag_sign;
  logic [7:0] opcode;
  logic ready, done, op_unknown, cond_taken, writes_flags, mem_access;
  ocd_op_t op_class;
  logic [2:0] destination_field, source_field, cond_field;
  logic [7:0] dst_sel, src_sel;
  logic [1:0] pair_field, imm_bytes;
  logic [OCD_CNT_W-1:0] op_states;
  int n_mismatch = 0;
  int samples_checked = 0;

  ocd_decoder u_ocd_decoder (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .opcode(opcode),
    .opcode_valid(opcode_valid), .flag_zero(flag_zero), .flag_carry(flag_carry),
    .flag_parity(flag_parity), .flag_sign(flag_sign), .ready(ready), .done(done),
    .op_class(op_class), .op_unknown(op_unknown), .destination_field(destination_field),
    .source_field(source_field), .dst_sel(dst_sel), .src_sel(src_sel), .pair_field(pair_field),
    .cond_field(cond_field), .cond_taken(cond_taken), .imm_bytes(imm_bytes),
    .writes_flags(writes_flags), .mem_access(mem_access), .op_states(op_states));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Issues one opcode, optionally stalls with ce low or keeps valid high while busy.
  task automatic run(input logic [7:0] opc, input logic [4:0] len, input int stall, input bit pester);
    int k;
    opcode = opc;
    opcode_valid = 1'b1;
    @(negedge ref_clk);
    if (pester) begin
      opcode = 8'hCD;
    end else begin
      opcode_valid = 1'b0;
    end
    check(8'(ready), 8'h00, "ready while busy");
    check(8'(op_states), 8'(len), "length");
    k = 0;
    if (stall > 0) begin
      ce = 1'b0;
      repeat (stall) @(negedge ref_clk);
      ce = 1'b1;
      k = stall;
    end
    while (done !== 1'b1 && k < 60) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 60) begin
      n_mismatch++;
      $display("BAD %0t no completion", $time);
      print_verdict();
    end
    check(8'(k), 8'(len) + 8'(stall), "completion time");
    check(8'(ready), 8'h01, "ready after completion");
  endtask

  task automatic t_reset();
    check(8'(ready), 8'h01, "reset ready");
    check(8'(done), 8'h00, "reset done");
    check(8'(op_class), 8'(OCD_OP_UNKNOWN), "reset class");
    check(8'(op_states), 8'h00, "reset length");
  endtask

  task automatic t_copy();
    for (int d = 0; d < 8; d++) begin
      for (int s = 0; s < 8; s++) begin
        if (d != 6 && s != 6) begin
          run({2'b01, 3'(d), 3'(s)}, 5'd5, 0, d == s);
          check(dst_sel, 8'h01 << d, "copy destination select");
          check(src_sel, 8'h01 << s, "copy source select");
          check(8'(destination_field), 8'(d), "destination field");
          check(8'(source_field), 8'(s), "source field");
        end
      end
    end
  endtask

  task automatic t_mem();
    for (int r = 0; r < 8; r++) begin
      if (r != 6) begin
        run({5'b01110, 3'(r)}, 5'd7, 0, 1'b0);
        check(src_sel, 8'h01 << r, "store source");
        check(dst_sel, 8'h40, "store target memory");
        check(8'(mem_access), 8'h01, "store memory use");
        run({2'b01, 3'(r), 3'b110}, 5'd7, 0, 1'b0);
        check(dst_sel, 8'h01 << r, "load destination");
        check(src_sel, 8'h40, "load source memory");
        run({5'b10001, 3'(r)}, 5'd4, 0, 1'b0);
        check(8'(writes_flags), 8'h01, "register add flags");
        run({2'b00, 3'(r), 3'b110}, 5'd7, 0, 1'b0);
        check(8'(imm_bytes), 8'h01, "immediate byte count");
      end
    end
  endtask

  task automatic t_cond();
    logic [3:0] f;
    bit met;
    for (int p = 0; p < 5; p++) begin
      f = (p < 4) ? 4'h1 << p : 4'h0;
      {flag_sign, flag_parity, flag_carry, flag_zero} = f;
      for (int c = 0; c < 8; c++) begin
        met = c[0] ? f[c[2:1]] : !f[c[2:1]];
        run({2'b11, 3'(c), 3'b100}, met ? 5'd17 : 5'd11, 0, 1'b0);
        check(8'(cond_taken), 8'(met), "invoke condition");
        check(8'(cond_field), 8'(c), "condition field");
        run({2'b11, 3'(c), 3'b000}, met ? 5'd11 : 5'd5, 0, 1'b0);
        check(8'(cond_taken), 8'(met), "return condition");
      end
    end
  endtask

  task automatic t_pair();
    for (int rp = 0; rp < 4; rp++) begin
      run({2'b00, 2'(rp), 4'b1011}, 5'd5, 0, 1'b0);
      check(8'(pair_field), 8'(rp), "pair field");
      check(8'(writes_flags), 8'h00, "pair flags untouched");
    end
  endtask

  task automatic t_table();
    logic [7:0] opc [16] = '{8'hCD, 8'hC9, 8'hCE, 8'h8E, 8'h36, 8'hE6, 8'h2F, 8'h37,
      8'h3F, 8'h27, 8'hFB, 8'hF3, 8'h00, 8'h22, 8'h2A, 8'h76};
    logic [4:0] len [16] = '{5'd17, 5'd10, 5'd7, 5'd7, 5'd10, 5'd7, 5'd4, 5'd4,
      5'd4, 5'd4, 5'd4, 5'd4, 5'd4, 5'd16, 5'd16, 5'd1};
    logic [1:0] imm [16] = '{2'd2, 2'd0, 2'd1, 2'd0, 2'd1, 2'd1, 2'd0, 2'd0,
      2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 2'd2, 2'd2, 2'd0};
    ocd_op_t cls [16] = '{OCD_OP_CALL, OCD_OP_RET, OCD_OP_ADC_IMM, OCD_OP_ADC_MEM, OCD_OP_IMM_MEM,
      OCD_OP_AND_IMM, OCD_OP_ACC_INV, OCD_OP_CARRY_SET, OCD_OP_CARRY_INV, OCD_OP_DEC_ADJ,
      OCD_OP_INT_ALLOW, OCD_OP_INT_BLOCK, OCD_OP_IDLE, OCD_OP_PAIR_STORE, OCD_OP_PAIR_LOAD, OCD_OP_UNKNOWN};
    for (int i = 0; i < 16; i++) begin
      run(opc[i], len[i], (i == 1) ? 3 : 0, i == 0);
      check(8'(op_class), 8'(cls[i]), "class");
      check(8'(imm_bytes), 8'(imm[i]), "operand bytes");
      check(8'(op_unknown), 8'(i == 15), "unknown flag");
      check(8'(writes_flags), 8'(opc[i] inside {8'hCE, 8'h8E, 8'hE6, 8'h27, 8'h37, 8'h3F}),
        "flag update");
      check(8'(mem_access), 8'(opc[i] inside {8'hCD, 8'hC9, 8'h8E, 8'h36, 8'h22, 8'h2A}),
        "memory use");
    end
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    opcode = 8'h00;
    opcode_valid = 1'b0;
    {flag_sign, flag_parity, flag_carry, flag_zero} = 4'h0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    t_reset();
    nrst = 1'b1;
    @(negedge ref_clk);
    t_copy();
    t_mem();
    t_cond();
    t_pair();
    t_table();
    opcode_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
    print_verdict();
  end
endmodule
